// File: shared/virq_pkg.sv
// constants and types shared by the vectored interrupt controller
package virq_pkg;
   localparam int unsigned NUM_LINES     = 32;
   localparam int unsigned NUM_SLOTS     = 16;
   localparam logic [31:0] BASE_ADDR     = 32'hFFFFF000;
   localparam logic [31:0] BASE_MASK     = 32'hFFFFF000;
   // register offsets within the block
   localparam logic [11:0] OFF_NORM_STAT = 12'h000;
   localparam logic [11:0] OFF_FAST_STAT = 12'h004;
   localparam logic [11:0] OFF_RAW       = 12'h008;
   localparam logic [11:0] OFF_ROUTE     = 12'h00C;
   localparam logic [11:0] OFF_ENABLE    = 12'h010;
   localparam logic [11:0] OFF_EN_CLEAR  = 12'h014;
   localparam logic [11:0] OFF_SOFT      = 12'h018;
   localparam logic [11:0] OFF_SOFT_CLR  = 12'h01C;
   localparam logic [11:0] OFF_CUR_PTR   = 12'h030;
   localparam logic [11:0] OFF_FALLBACK  = 12'h034;
   localparam logic [11:0] OFF_SLOT_PTR  = 12'h100;
   localparam logic [11:0] OFF_SLOT_CTL  = 12'h200;
   // slot control layout: source index in [4:0], slot enable in bit 5
   localparam int unsigned CTL_SRC_LSB   = 0;
   localparam int unsigned CTL_EN_BIT    = 5;
   localparam logic [31:0] RST_WORD      = 32'h00000000;
   localparam logic [5:0]  RST_CTL       = 6'h00;
   // priority logic state
   typedef enum logic [1:0] {
      VIRQ_IDLE,
      VIRQ_LATCH,
      VIRQ_HELD
   } virq_state_t;
endpackage : virq_pkg

// File: rtl/virq_slot.sv
// one vector slot: control word, handler pointer and request match
`timescale 1ns/1ps
`default_nettype none
module virq_slot #(
   parameter int unsigned LINES = 32
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   input  wire logic              wr_ptr,
   input  wire logic              wr_ctl,
   input  wire logic [31:0]       wdata,
   input  wire logic [LINES-1:0]  normal_req,
   output logic [31:0]            handler_ptr,
   output logic [5:0]             ctl,
   output logic                   hit
);
   initial begin
      if (LINES != 32) $error("slot source field serves exactly 32 lines");
   end

   // per-slot handler pointer and control hold across disable
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         handler_ptr <= virq_pkg::RST_WORD;
         ctl         <= virq_pkg::RST_CTL;
      end else if (ce) begin
         if (wr_ptr) handler_ptr <= wdata;
         if (wr_ctl) ctl <= wdata[5:0];
      end
   end

   // enabled slot claims its assigned normal-path source
   wire logic [4:0] src_idx = ctl[virq_pkg::CTL_SRC_LSB +: 5];
   assign hit = ctl[virq_pkg::CTL_EN_BIT] & normal_req[src_idx];
endmodule : virq_slot
`default_nettype wire

// File: rtl/virq_ctrl.sv
// vectored interrupt controller with classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - soft trigger bit equals high source level
// - all sources are active-high levels
// - raw status visible, then enable-masked
// - disabled lines stay pending, fire when enabled
// - route select steers fast or normal
// - fast path drives fast output directly
// - normal requests match to assigned slot
// - unassigned normal requests use fallback
// - slot pointer loaded, normal output raised
// - fallback pointer shared by unassigned lines
// - acknowledge write releases, re-asserts if pending
// - lines resampled after acknowledge
// - zero wait, write takes two clocks
// - block decodes at fixed base address
// - slot 0 highest, fallback lowest priority
// - route bit 0 normal, 1 fast
// - enable write 1 sets, 0 ignored
module virq_ctrl #(
   parameter int unsigned LINES = 32,
   parameter int unsigned SLOTS = 16
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   input  wire logic [LINES-1:0]  src_level,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [31:0]       wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   wb_err_o,
   output logic                   normal_irq,
   output logic                   fast_request
);
   initial begin
      if (LINES != virq_pkg::NUM_LINES) $error("LINES must be 32");
      if (SLOTS < 1 || SLOTS > virq_pkg::NUM_SLOTS) $error("SLOTS must be 1..16");
   end

   logic [31:0] soft_trigger_reg;
   logic [31:0] line_enable_mask;
   logic [31:0] fast_route_select;
   logic [31:0] fallback_handler_pointer;
   logic [31:0] current_handler_pointer;
   logic [31:0] raw_pending_status;
   virq_pkg::virq_state_t state;
   // write stage: command latched with the request, applied at the ack edge
   logic        wr_pend;
   logic [11:0] wr_off;
   logic [31:0] wr_data;

   // register map, byte offsets from the block base:
   //   000 normal masked status, read only
   //   004 fast masked status, read only
   //   008 raw levels, source or soft bit
   //   00C route select, a one picks the fast path
   //   010 enable, ones set, reads back the mask
   //   014 enable clear, ones clear
   //   018 soft trigger, ones set
   //   01C soft trigger clear, ones clear
   //   020, 300 to 310 reserved
   //   030 current pointer; any full-word write acknowledges
   //   034 fallback pointer
   //   100 + 4n slot n handler pointer
   //   200 + 4n slot n control: source [4:0], enable [5]
   // anything unmapped, reserved holes too, answers err
   // partial writes are acknowledged but ignored, so software
   // never leaves half a pointer behind
   // bus decode
   wire logic        in_block = (wb_adr_i & virq_pkg::BASE_MASK) == virq_pkg::BASE_ADDR;
   wire logic [11:0] off      = wb_adr_i[11:0];
   wire logic        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire logic        is_slot_ptr = off[11:6] == virq_pkg::OFF_SLOT_PTR[11:6];
   wire logic        is_slot_ctl = off[11:6] == virq_pkg::OFF_SLOT_CTL[11:6];
   // one hit per fixed register; holes between them stay unmapped
   wire logic        hit_norm     = off == virq_pkg::OFF_NORM_STAT;
   wire logic        hit_fast     = off == virq_pkg::OFF_FAST_STAT;
   wire logic        hit_raw      = off == virq_pkg::OFF_RAW;
   wire logic        hit_route    = off == virq_pkg::OFF_ROUTE;
   wire logic        hit_enable   = off == virq_pkg::OFF_ENABLE;
   wire logic        hit_en_clr   = off == virq_pkg::OFF_EN_CLEAR;
   wire logic        hit_soft     = off == virq_pkg::OFF_SOFT;
   wire logic        hit_soft_clr = off == virq_pkg::OFF_SOFT_CLR;
   wire logic        hit_cur      = off == virq_pkg::OFF_CUR_PTR;
   wire logic        hit_fall     = off == virq_pkg::OFF_FALLBACK;
   wire logic        is_fixed     = hit_norm | hit_fast | hit_raw | hit_route | hit_enable
                                  | hit_en_clr | hit_soft | hit_soft_clr | hit_cur | hit_fall;
   wire logic        slot_ok   = (is_slot_ptr | is_slot_ctl) & ({2'b00, off[5:2]} < SLOTS[5:0])
                                & (off[1:0] == 2'b00);
   wire logic        mapped    = in_block & (is_fixed | slot_ok);
   wire logic        full_word = wb_sel_i == 4'hF;

   // write decode from the delayed write stage
   // the stage holds one word; each write gets its own applying edge
   wire logic w_route   = wr_pend & (wr_off == virq_pkg::OFF_ROUTE);
   wire logic w_enable  = wr_pend & (wr_off == virq_pkg::OFF_ENABLE);
   wire logic w_en_clr  = wr_pend & (wr_off == virq_pkg::OFF_EN_CLEAR);
   wire logic w_soft    = wr_pend & (wr_off == virq_pkg::OFF_SOFT);
   wire logic w_soft_cl = wr_pend & (wr_off == virq_pkg::OFF_SOFT_CLR);
   wire logic w_ack     = wr_pend & (wr_off == virq_pkg::OFF_CUR_PTR);
   wire logic w_fall    = wr_pend & (wr_off == virq_pkg::OFF_FALLBACK);
   wire logic [3:0] w_idx = wr_off[5:2];

   // datapath from pins to the two outputs:
   //   raw = source level or soft bit
   //   enabled = raw and mask; masked lines keep their raw level
   //   fast status = enabled and route; straight to the output flop
   //   normal status = enabled and not route; to slots and fallback
   // request datapath
   assign raw_pending_status = src_level | soft_trigger_reg;
   wire logic [31:0] enabled_req = raw_pending_status & line_enable_mask;
   wire logic [31:0] fast_status = enabled_req & fast_route_select;
   wire logic [31:0] norm_status = enabled_req & ~fast_route_select;

   // vector slots
   logic [31:0] slot_ptr [SLOTS];
   logic [5:0]  slot_ctl [SLOTS];
   logic [SLOTS-1:0] slot_hit;
   logic [31:0] claimed;
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         // strobes for this slot from the delayed write stage
         wire logic sel_here = wr_pend & (w_idx == 4'(g));
         wire logic sel_ptr  = sel_here & (wr_off[11:6] == virq_pkg::OFF_SLOT_PTR[11:6]);
         wire logic sel_ctl  = sel_here & (wr_off[11:6] == virq_pkg::OFF_SLOT_CTL[11:6]);
         virq_slot #(.LINES(LINES)) u_slot (
            .clk         (clk),
            .reset       (reset),
            .ce          (ce),
            .wr_ptr      (sel_ptr),
            .wr_ctl      (sel_ctl),
            .wdata       (wr_data),
            .normal_req  (norm_status),
            .handler_ptr (slot_ptr[g]),
            .ctl         (slot_ctl[g]),
            .hit         (slot_hit[g])
         );
      end
   endgenerate

   // lines owned by an enabled slot are not default-vectored
   // a slot with its enable clear claims nothing, its line falls back
   always_comb begin
      claimed = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (slot_ctl[i][virq_pkg::CTL_EN_BIT]) begin
            claimed[slot_ctl[i][4:0]] = 1'b1;
         end
      end
   end
   wire logic default_req = |(norm_status & ~claimed);

   // fixed priority: lowest slot index wins, fallback last
   // loop runs from the top slot down, so the last hit kept is the lowest;
   // a line claimed by two slots vectors through the lower one
   logic        any_hit;
   logic [31:0] win_ptr;
   always_comb begin
      any_hit = 1'b0;
      win_ptr = fallback_handler_pointer;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (slot_hit[i]) begin
            any_hit = 1'b1;
            win_ptr = slot_ptr[i];
         end
      end
   end
   wire logic any_norm = any_hit | default_req;

   // read mux on the live state; a write lands before the next read is taken, so that read sees the new value
   // status words are combinational, so they track source levels every cycle
   logic [31:0] rd_val;
   always_comb begin
      rd_val = '0;
      if (is_slot_ptr & slot_ok) rd_val = slot_ptr[off[5:2]];
      else if (is_slot_ctl & slot_ok) rd_val = {26'h0, slot_ctl[off[5:2]]};
      else begin
         case (off)
            virq_pkg::OFF_NORM_STAT: rd_val = norm_status;
            virq_pkg::OFF_FAST_STAT: rd_val = fast_status;
            virq_pkg::OFF_RAW:       rd_val = raw_pending_status;
            virq_pkg::OFF_ROUTE:     rd_val = fast_route_select;
            virq_pkg::OFF_ENABLE:    rd_val = line_enable_mask;
            virq_pkg::OFF_SOFT:      rd_val = soft_trigger_reg;
            virq_pkg::OFF_CUR_PTR:   rd_val = current_handler_pointer;
            virq_pkg::OFF_FALLBACK:  rd_val = fallback_handler_pointer;
            default:                 rd_val = '0;
         endcase
      end
   end

   // answer values; one request gives exactly one ack or err
   wire logic        next_ack   = req & mapped;
   wire logic        next_err   = req & ~mapped;
   wire logic [31:0] next_rdata = (next_ack & ~wb_we_i) ? rd_val : virq_pkg::RST_WORD;
   wire logic        next_wr    = next_ack & wb_we_i & full_word;

   // wishbone answer: one cycle after the request, no stall
   // edge 1 takes the request, edge 2 shows ack and read data;
   // a write lands at edge 2, so a read taken later sees it
   // ack masks req, so a strobe held over the ack edge is not taken twice
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= virq_pkg::RST_WORD;
      end else if (ce) begin
         wb_ack_o <= next_ack;
         wb_err_o <= next_err; // reserved or foreign offsets
         wb_dat_o <= next_rdata;
      end
   end

   // write stage: taken with the request, state changes at the ack edge
   // one stage suffices: a classic master idles between requests
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend <= 1'b0;
         wr_off  <= 12'h000;
         wr_data <= virq_pkg::RST_WORD;
      end else if (ce) begin
         wr_pend <= next_wr;
         wr_off  <= off;
         wr_data <= wb_dat_i;
      end
   end

   // next configuration values; set and clear offsets never meet in one cycle
   wire logic [31:0] next_enable   = w_enable ? (line_enable_mask | wr_data)
                                   : w_en_clr ? (line_enable_mask & ~wr_data)
                                   : line_enable_mask;
   wire logic [31:0] next_route    = w_route ? wr_data : fast_route_select;
   wire logic [31:0] next_soft     = w_soft ? (soft_trigger_reg | wr_data)
                                   : w_soft_cl ? (soft_trigger_reg & ~wr_data)
                                   : soft_trigger_reg;
   wire logic [31:0] next_fallback = w_fall ? wr_data : fallback_handler_pointer;

   // enable mask; a disabled line is never cleared, it just waits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         line_enable_mask <= virq_pkg::RST_WORD;
      end else if (ce) begin
         line_enable_mask <= next_enable;
      end
   end

   // route select, written as a whole word
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_route_select <= virq_pkg::RST_WORD;
      end else if (ce) begin
         fast_route_select <= next_route;
      end
   end

   // soft trigger; stays set until software clears it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         soft_trigger_reg <= virq_pkg::RST_WORD;
      end else if (ce) begin
         soft_trigger_reg <= next_soft;
      end
   end

   // fallback pointer, one for all unassigned lines
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fallback_handler_pointer <= virq_pkg::RST_WORD;
      end else if (ce) begin
         fallback_handler_pointer <= next_fallback;
      end
   end

   // priority logic next state: latch winner pointer, hold until acknowledge write
   virq_pkg::virq_state_t next_state;
   logic [31:0]           next_cur_ptr;
   logic                  next_normal_irq;
   always_comb begin
      next_state      = state;
      next_cur_ptr    = current_handler_pointer;
      next_normal_irq = normal_irq;
      case (state)
         virq_pkg::VIRQ_IDLE: begin
            // first request latches its pointer at once
            if (any_norm) begin
               next_cur_ptr    = win_ptr;
               next_normal_irq = 1'b1;
               next_state      = virq_pkg::VIRQ_HELD;
            end
         end
         virq_pkg::VIRQ_HELD: begin
            // source may drop before ack; the line follows it, pointer stays
            next_normal_irq = any_norm;
            if (w_ack) begin
               next_normal_irq = 1'b0;
               next_state      = virq_pkg::VIRQ_LATCH;
            end
         end
         virq_pkg::VIRQ_LATCH: begin
            // resample lines after release; pending ones re-assert at once
            next_state = virq_pkg::VIRQ_IDLE;
            if (any_norm) begin
               next_cur_ptr    = win_ptr;
               next_normal_irq = 1'b1;
               next_state      = virq_pkg::VIRQ_HELD;
            end
         end
         default: begin
            next_state      = virq_pkg::VIRQ_IDLE;
            next_normal_irq = 1'b0;
         end
      endcase
   end

   // registered outputs; the fast path skips arbitration entirely
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state                   <= virq_pkg::VIRQ_IDLE;
         current_handler_pointer <= virq_pkg::RST_WORD;
         normal_irq              <= 1'b0;
         fast_request            <= 1'b0;
      end else if (ce) begin
         state                   <= next_state;
         current_handler_pointer <= next_cur_ptr;
         normal_irq              <= next_normal_irq;
         fast_request            <= |fast_status;
      end
   end
endmodule : virq_ctrl
`default_nettype wire

// File: bench/virq_core_model.sv
// processor core model counting interrupt entries
`timescale 1ns/1ps
`default_nettype none
module virq_core_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic normal_irq,
   input  wire logic fast_request,
   output var  int   irq_entries,
   output var  int   fiq_entries
);
   logic irq_q;
   logic fiq_q;
   // one entry per rising request; a held level is a single exception
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {irq_q, fiq_q} <= 2'b00;
         irq_entries    <= 0;
         fiq_entries    <= 0;
      end else begin
         {irq_q, fiq_q} <= {normal_irq, fast_request};
         irq_entries    <= irq_entries + int'(normal_irq & ~irq_q);
         fiq_entries    <= fiq_entries + int'(fast_request & ~fiq_q);
      end
   end
endmodule : virq_core_model
`default_nettype wire

// File: bench/virq_ctrl_sva.sv
// bus and interrupt output checks for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module virq_ctrl_sva #(
   parameter int unsigned LINES = 32,
   parameter int unsigned SLOTS = 16
) (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        normal_irq,
   input wire logic        fast_request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // request decode; reserved holes answer with err
   wire       taken = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o & ce;
   wire       inbase = (wb_adr_i & virq_pkg::BASE_MASK) == virq_pkg::BASE_ADDR;
   wire [11:0] off = wb_adr_i[11:0];
   wire       rsv = (off == 12'h020) || (off >= 12'h300 && off <= 12'h310);
   wire       ackw = wb_ack_o & wb_we_i & (wb_sel_i == 4'hF) & ce;
   ack_one_a: assert property (taken |=> wb_ack_o ^ wb_err_o)
      else $error("bus answer missing one cycle after request");
   ack_pulse_a: assert property ((wb_ack_o || wb_err_o) && ce |=> !wb_ack_o && !wb_err_o)
      else $error("bus answer longer than one cycle");
   rsv_err_a: assert property (taken && rsv |=> wb_err_o && !wb_ack_o)
      else $error("reserved offset not refused");
   base_err_a: assert property (taken && !inbase |=> wb_err_o)
      else $error("address outside block not refused");
   map_ack_a: assert property (taken && inbase && off == 12'h030 |=> wb_ack_o)
      else $error("handler pointer not acknowledged");
   ack_release_a: assert property (ackw && off == 12'h030 |-> ##[1:2] !normal_irq)
      else $error("acknowledge write did not release normal request");
   reset_quiet_a: assert property ($past(reset) |-> !normal_irq && !fast_request && !wb_ack_o)
      else $error("outputs active after reset");
   ce_freeze_a: assert property (!ce |=> $stable(normal_irq) && $stable(fast_request))
      else $error("outputs moved with clock enable low");
endmodule : virq_ctrl_sva
bind virq_ctrl virq_ctrl_sva #(.LINES(LINES), .SLOTS(SLOTS)) u_virq_ctrl_sva (
   .clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .normal_irq(normal_irq), .fast_request(fast_request));
`default_nettype wire

// File: bench/tb_virq_ctrl.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_virq_ctrl;
   logic        clk, reset, ce, cyc, stb, we, wb_ack_o, wb_err_o, normal_irq, fast_request;
   logic [31:0] src, adr, wdat, rd, wb_dat_o;
   logic [3:0]  sel = 4'hF;
   logic        last_err;
   int          fails = 0, total_checks = 0, cycles = 0, fiq_n, irq_n;
   logic [11:0] offs [11] = '{12'h000, 12'h004, 12'h00C, 12'h010, 12'h018, 12'h030,
                             12'h034, 12'h100, 12'h13C, 12'h200, 12'h23C};
   logic [31:0] bad [4] = '{32'hFFFFF020, 32'hFFFFF300, 32'hFFFFF310, 32'hFFFFE000};
   virq_ctrl #(.LINES(32), .SLOTS(16)) u_virq_ctrl (.clk(clk), .reset(reset), .ce(ce),
      .src_level(src), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wb_err_o(wb_err_o), .normal_irq(normal_irq), .fast_request(fast_request));
   virq_core_model u_virq_core_model (.clk(clk), .reset(reset), .normal_irq(normal_irq),
      .fast_request(fast_request), .irq_entries(irq_n), .fiq_entries(fiq_n));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // classic cycle: hold everything until ack or err, release, then idle a cycle
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we} <= {2'b11, w};
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      last_err = wb_err_o;
      {cyc, stb, we} <= 3'b000;
   endtask : xfer
   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      xfer(1'b1, virq_pkg::BASE_ADDR | {20'h0, o}, d);
   endtask : wr
   task automatic rdc(input logic [11:0] o, input logic [31:0] exp);
      xfer(1'b0, virq_pkg::BASE_ADDR | {20'h0, o}, 32'h0);
      chk(rd, exp);
   endtask : rdc
   // acknowledge; release lands at the ack edge, then let the re-latch edge and one more pass
   task automatic ack_irq();
      wr(12'h030, 32'h0);
      repeat (2) @(posedge clk);
   endtask : ack_irq
   initial begin
      {reset, ce, cyc, stb, we} = 5'b11000;
      {src, adr, wdat} = 96'h0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      foreach (offs[i]) rdc(offs[i], 32'h0);
      chk({30'h0, normal_irq, fast_request}, 32'h0);
      $display("test reset values finished");
      foreach (bad[i]) begin
         xfer(1'b0, bad[i], 32'h0);
         chk({31'h0, last_err}, 32'h1);
      end
      $display("test refused addresses finished");
      // disabled line stays pending and fires on enable through fallback
      src <= 32'h8;
      wr(12'h034, 32'h1000);
      rdc(12'h008, 32'h8);
      rdc(12'h000, 32'h0);
      wr(12'h010, 32'h8);
      wr(12'h010, 32'h0);
      rdc(12'h010, 32'h8);
      rdc(12'h000, 32'h8);
      rdc(12'h030, 32'h1000);
      chk({31'h0, normal_irq}, 32'h1);
      $display("test masking and fallback finished");
      // slot 0 takes line 6, slot 2 takes line 5, line 3 stays fallback
      wr(12'h200, 32'h26);
      wr(12'h100, 32'h2000);
      wr(12'h208, 32'h25);
      wr(12'h108, 32'h2200);
      wr(12'h010, 32'h60);
      src <= 32'h68;
      rdc(12'h030, 32'h1000);
      ack_irq();
      rdc(12'h030, 32'h2000);
      xfer(1'b0, 32'h00000020 - 32'h00000FF0, 32'h0);
      chk(rd, 32'h2000);
      src <= 32'h28;
      ack_irq();
      rdc(12'h030, 32'h2200);
      src <= 32'h08;
      ack_irq();
      rdc(12'h030, 32'h1000);
      src <= 32'h0;
      ack_irq();
      chk({31'h0, normal_irq}, 32'h0);
      chk(irq_n, 32'h4);
      $display("test priority and acknowledge finished");
      // soft trigger on a fast-routed line
      wr(12'h00C, 32'h200);
      wr(12'h010, 32'h200);
      wr(12'h018, 32'h200);
      rdc(12'h004, 32'h200);
      rdc(12'h000, 32'h0);
      chk({30'h0, normal_irq, fast_request}, 32'h1);
      wr(12'h01C, 32'h200);
      rdc(12'h004, 32'h0);
      chk(fiq_n, 32'h1);
      $display("test fast path finished");
      // frozen while clock enable is low, fires once it returns
      ce <= 1'b0;
      src <= 32'h8;
      repeat (4) @(posedge clk);
      chk({31'h0, normal_irq}, 32'h0);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, normal_irq}, 32'h1);
      $display("test clock enable finished");
      stop_test();
   end
endmodule : tb_virq_ctrl
`default_nettype wire
